// ---- pkg/isc_pkg.sv ----
// Register map, field limits and types for the SCL timing-count block
package isc_pkg;
    localparam int ADDR_W = 32;
    localparam int CNT_W  = 16;

    localparam logic [31:0] STD_HIGH_OFF  = 32'h5000_1514;
    localparam logic [31:0] STD_LOW_OFF   = 32'h5000_1518;
    localparam logic [31:0] FAST_HIGH_OFF = 32'h5000_151C;
    localparam logic [31:0] FAST_LOW_OFF  = 32'h5000_1520;
    localparam logic [31:0] CTRL_OFF      = 32'h5000_1500;
    localparam logic [31:0] STATUS_OFF    = 32'h5000_1504;

    localparam logic [15:0] STD_HIGH_RST  = 16'h0048;
    localparam logic [15:0] STD_LOW_RST   = 16'h004F;
    localparam logic [15:0] FAST_HIGH_RST = 16'h0008;
    localparam logic [15:0] FAST_LOW_RST  = 16'h0017;

    localparam logic [15:0] HIGH_MIN      = 16'h0006;
    localparam logic [15:0] LOW_MIN       = 16'h0008;
    localparam logic [15:0] IDLE_EXTRA    = 16'h000A;

    // Control register fields
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_FAST_BIT  = 1;
    localparam int CTRL_HS_BIT    = 2;
    localparam int CTRL_HSPRE_BIT = 3;
    // Status register fields
    localparam int STAT_IDLE_BIT  = 0;
    localparam int STAT_SCL_BIT   = 1;
    localparam int STAT_EN_BIT    = 2;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } isc_req_t;

    typedef struct packed {
        logic [15:0] high;
        logic [15:0] low;
    } isc_pair_t;

    typedef enum logic [1:0] {
        ISC_OFF  = 2'b00,
        ISC_LOW  = 2'b01,
        ISC_HIGH = 2'b10
    } isc_state_t;
endpackage

// ---- src/isc_scl_timing.sv ----
// SCL timing-count registers, SCL phase generator and bus-idle detector
// Notes on behaviour
// - Standard high count sets SCL high cycles
// - Standard low count sets SCL low cycles
// - Fast high count sets fast SCL high
// - Fast low count sets fast SCL low
// - High-speed preamble uses the fast pair
// - Count writes ignored while controller enabled
// - High counts below 6 stored as 6
// - Low counts below 8 stored as 8
// - Idle flagged at standard high plus ten
`timescale 1ns/1ps
module isc_scl_timing
    import isc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [31:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    output logic             bus_idle
);

    isc_req_t    req;
    isc_pair_t   std_r;
    isc_pair_t   fast_r;
    isc_pair_t   sel;
    isc_state_t  state_r;
    logic        enable_r;
    logic        fast_mode_r;
    logic        hs_mode_r;
    logic        hs_pre_r;
    logic [15:0] phase_r;
    logic [15:0] idle_cnt_r;
    logic [15:0] idle_lim;
    logic        scl_s1_r;
    logic        scl_s2_r;
    logic        scl_prev_r;
    logic        cfg_wr_ok;

    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // Raise a written count to its floor
    function automatic logic [15:0] clamp(input logic [15:0] v,
                                          input logic [15:0] floor);
        clamp = (v < floor) ? floor : v;
    endfunction

    assign cfg_wr_ok = req.wr && !enable_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            std_r  <= '{high: STD_HIGH_RST, low: STD_LOW_RST};
            fast_r <= '{high: FAST_HIGH_RST, low: FAST_LOW_RST};
        end else if (cfg_wr_ok) begin
            case (req.addr)
                STD_HIGH_OFF: begin
                    std_r.high <= clamp(req.wdata[15:0], HIGH_MIN);
                end
                STD_LOW_OFF: begin
                    std_r.low <= clamp(req.wdata[15:0], LOW_MIN);
                end
                FAST_HIGH_OFF: begin
                    fast_r.high <= clamp(req.wdata[15:0], HIGH_MIN);
                end
                FAST_LOW_OFF: begin
                    fast_r.low <= clamp(req.wdata[15:0], LOW_MIN);
                end
                default: begin
                end
            endcase
        end
    end

    // Control is always writable so software can disable the controller
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            enable_r    <= 1'b0;
            fast_mode_r <= 1'b0;
            hs_mode_r   <= 1'b0;
            hs_pre_r    <= 1'b0;
        end else if (req.wr && req.addr == CTRL_OFF) begin
            enable_r    <= req.wdata[CTRL_EN_BIT];
            fast_mode_r <= req.wdata[CTRL_FAST_BIT];
            hs_mode_r   <= req.wdata[CTRL_HS_BIT];
            hs_pre_r    <= req.wdata[CTRL_HSPRE_BIT];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 32'h0000_0000;
        end else if (req.rd) begin
            case (req.addr)
                STD_HIGH_OFF:  rdata <= {16'h0000, std_r.high};
                STD_LOW_OFF:   rdata <= {16'h0000, std_r.low};
                FAST_HIGH_OFF: rdata <= {16'h0000, fast_r.high};
                FAST_LOW_OFF:  rdata <= {16'h0000, fast_r.low};
                CTRL_OFF:      rdata <= {28'h0000000, hs_pre_r, hs_mode_r,
                                         fast_mode_r, enable_r};
                STATUS_OFF:    rdata <= {29'h00000000, enable_r, scl_s2_r,
                                         bus_idle};
                default:       rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

    always_comb begin
        if (hs_mode_r) begin
            // High-speed counts live elsewhere; the preamble is timed with the fast pair, the rest with the standard pair
            sel = hs_pre_r ? fast_r : std_r;
        end else if (fast_mode_r) begin
            sel = fast_r;
        end else begin
            sel = std_r;
        end
    end

    // reload phase counter at each SCL edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ISC_OFF;
            phase_r <= 16'h0000;
            scl_out <= 1'b0;
            scl_oe  <= 1'b0;
        end else begin
            case (state_r)
                ISC_OFF: begin
                    scl_oe  <= 1'b0;
                    scl_out <= 1'b0;
                    if (enable_r) begin
                        state_r <= ISC_LOW;
                        phase_r <= sel.low - 16'h0001;
                        scl_oe  <= 1'b1;
                    end
                end
                ISC_LOW: begin
                    if (!enable_r) begin
                        state_r <= ISC_OFF;
                        scl_oe  <= 1'b0;
                    end else if (phase_r == 16'h0000) begin
                        state_r <= ISC_HIGH;
                        phase_r <= sel.high - 16'h0001;
                        scl_oe  <= 1'b0;
                    end else begin
                        phase_r <= phase_r - 16'h0001;
                    end
                end
                ISC_HIGH: begin
                    if (!enable_r) begin
                        state_r <= ISC_OFF;
                    end else if (phase_r == 16'h0000) begin
                        state_r <= ISC_LOW;
                        phase_r <= sel.low - 16'h0001;
                        scl_oe  <= 1'b1;
                    end else begin
                        phase_r <= phase_r - 16'h0001;
                    end
                end
                default: begin
                    state_r <= ISC_OFF;
                    scl_oe  <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_s1_r   <= 1'b1;
            scl_s2_r   <= 1'b1;
            scl_prev_r <= 1'b1;
        end else begin
            scl_s1_r   <= scl_in;
            scl_s2_r   <= scl_s1_r;
            scl_prev_r <= scl_s2_r;
        end
    end

    // idle limit, wraps if software breaks the 65525 ceiling
    assign idle_lim = std_r.high + IDLE_EXTRA;

    // idle counter, restarted by any SCL movement or low level
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            idle_cnt_r <= 16'h0000;
            bus_idle   <= 1'b0;
        end else if (!scl_s2_r || scl_s2_r != scl_prev_r) begin
            idle_cnt_r <= 16'h0000;
            bus_idle   <= 1'b0;
        end else if (idle_cnt_r == idle_lim) begin
            bus_idle   <= 1'b1;
        end else begin
            idle_cnt_r <= idle_cnt_r + 16'h0001;
        end
    end

endmodule

// ---- tb/isc_bus_model.sv ----
// Open-drain SCL wire with pull-up and a remote party that may hold it
`timescale 1ns/1ps
module isc_bus_model (
    input  wire logic scl_oe,
    input  wire logic hold_low,
    output logic      scl
);
    // Pull-up wins only when nobody pulls low
    assign scl = !(scl_oe || hold_low);
endmodule

// ---- tb/isc_scl_timing_tb_top.sv ----
// Self-checking bench for the SCL timing-count block
`timescale 1ns/1ps
module isc_scl_timing_tb_top;
    import isc_pkg::*;
    logic        clk, resetn, wr, rd, hold_low, scl_in, scl_oe, bus_idle;
    logic        scl_out;
    logic [31:0] addr, wdata, rdata;
    int          mismatches, num_checks, cycles;
    isc_scl_timing dut (.clk(clk), .resetn(resetn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .scl_in(scl_in),
        .scl_out(scl_out), .scl_oe(scl_oe), .bus_idle(bus_idle));
    isc_bus_model far (.scl_oe(scl_oe), .hold_low(hold_low), .scl(scl_in));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    // Write and/or read one place; an idle edge follows every access
    task automatic acc(logic [31:0] a, d, bit w, r, logic [31:0] e);
        addr <= a;
        wdata <= d;
        if (w) begin
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
        end
        if (r) begin
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1 chk("rdata", rdata, e);
        end
        @(posedge clk);
    endtask
    // Skips the first low phase, then times one high and one low phase
    task automatic per(logic [31:0] mode, int lo, hi);
        int n;
        acc(CTRL_OFF, mode, 1, 0, 0);
        #1;
        for (n = 0; n < 99 && scl_oe === 1'b1; n++) step();
        for (n = 0; n < 99 && scl_oe === 1'b0; n++) step();
        chk("high", n, hi);
        for (n = 0; n < 99 && scl_oe === 1'b1; n++) step();
        chk("low", n, lo);
        acc(CTRL_OFF, 32'h0, 1, 0, 0);
    endtask
    initial begin
        {resetn, wr, rd, hold_low} = 4'h0;
        {addr, wdata} = 64'h0;
        {mismatches, num_checks, cycles} = 0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        acc(STD_HIGH_OFF, 0, 0, 1, 32'h48);
        acc(STD_LOW_OFF, 0, 0, 1, 32'h4F);
        acc(FAST_HIGH_OFF, 0, 0, 1, 32'h8);
        acc(FAST_LOW_OFF, 0, 0, 1, 32'h17);
        acc(32'h5000_1524, 0, 0, 1, 32'h0);
        acc(STD_HIGH_OFF, 32'h5, 1, 1, 32'h6);
        acc(FAST_HIGH_OFF, 32'h0, 1, 1, 32'h6);
        acc(STD_LOW_OFF, 32'h7, 1, 1, 32'h8);
        acc(FAST_LOW_OFF, 32'h1, 1, 1, 32'h8);
        acc(STD_LOW_OFF, 32'h9, 1, 1, 32'h9);
        acc(FAST_HIGH_OFF, 32'h7, 1, 1, 32'h7);
        acc(CTRL_OFF, 32'h1, 1, 0, 0);
        acc(STD_LOW_OFF, 32'h20, 1, 1, 32'h9);
        acc(FAST_HIGH_OFF, 32'h20, 1, 1, 32'h7);
        acc(CTRL_OFF, 32'h0, 1, 0, 0);
        per(32'h1, 9, 6);
        per(32'h3, 8, 7);
        per(32'hD, 8, 7);
        per(32'h5, 9, 6);
        hold_low <= 1'b1;
        repeat (8) step();
        chk("idle", bus_idle, 1'b0);
        hold_low <= 1'b0;
        repeat (16) step();
        chk("idle", bus_idle, 1'b0);
        repeat (8) step();
        chk("idle", bus_idle, 1'b1);
        // Status: idle set, synced SCL high, controller disabled
        acc(STATUS_OFF, 0, 0, 1, 32'h3);
        acc(CTRL_OFF, 0, 0, 1, 32'h0);
        chk("scl_out", scl_out, 1'b0);
        print_verdict();
    end
endmodule
bind isc_scl_timing isc_sva u_sva (.clk(clk), .resetn(resetn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .scl_in(scl_in),
    .scl_oe(scl_oe), .bus_idle(bus_idle));

// ---- tb/isc_sva.sv ----
// Port checker for the SCL timing-count block
`timescale 1ns/1ps
module isc_sva
    import isc_pkg::*;
(
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic        scl_in,
    input wire logic        scl_oe,
    input wire logic        bus_idle
);
    logic en_r;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Shadow of the enable bit; count writes only count while it is low
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            en_r <= 1'b0;
        else if (wr && addr == CTRL_OFF)
            en_r <= wdata[CTRL_EN_BIT];
    end
    a_high_floor: assert property (
        wr && !en_r && wdata[15:0] < HIGH_MIN && (addr == STD_HIGH_OFF ||
        addr == FAST_HIGH_OFF) ##1 rd && $stable(addr) |=> rdata == 32'h6)
        else $error("high count below floor kept");
    a_low_floor: assert property (
        wr && !en_r && wdata[15:0] < LOW_MIN && (addr == STD_LOW_OFF ||
        addr == FAST_LOW_OFF) ##1 rd && $stable(addr) |=> rdata == 32'h8)
        else $error("low count below floor kept");
    a_oe_start: assert property ($rose(en_r) |=> scl_oe)
        else $error("low phase did not start");
    a_oe_stop: assert property ($fell(en_r) |-> ##[0:1] !scl_oe)
        else $error("pull-down kept after disable");
    a_low_hold: assert property (
        $rose(scl_oe) |=> (scl_oe || !en_r) [*7])
        else $error("low phase shorter than floor");
    a_high_hold: assert property (
        $fell(scl_oe) && en_r |=> (!scl_oe || !en_r) [*5])
        else $error("high phase shorter than floor");
    a_idle_cause: assert property (
        $rose(bus_idle) |-> $past(scl_in, 3) && $past(scl_in, 12))
        else $error("idle flagged without a long high");
    a_idle_drop: assert property ($fell(scl_in) |-> ##[1:4] !bus_idle)
        else $error("idle kept after the line fell");
endmodule
